//--- debug_event_status_comparator.sv
// event flags, sequencer status and comparator a of the debug module, axi4-lite slave
// assumes cpu bus strobes, trigger, session end and sequencer requests are on aclk;
// only the external event pin is asynchronous
`timescale 1ns/1ps
`default_nettype none
module debug_event_status_comparator
    import dbg_event_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // watched cpu buses
    input wire logic [23:0] cpu_data_addr,
    input wire logic [31:0] cpu_data,
    input wire logic cpu_read,
    input wire logic cpu_data_valid,
    input wire logic [23:0] cpu_pc,
    input wire logic cpu_instruction_address_select_valid,
    // comparator a reference values held elsewhere
    input wire logic [23:0] cmp_a_addr,
    input wire logic [31:0] cmp_a_data,
    input wire logic [31:0] cmp_a_data_mask,
    // other channels, events and sequencer requests
    input wire logic [3:1] channel_match_in,
    input wire logic external_event_pin,
    input wire logic forced_trigger_event,
    input wire logic session_end_event,
    input wire logic seq_goto_valid,
    input wire logic [2:0] seq_goto_state,
    // outputs
    output logic comparator_a_match,
    output logic armed,
    output logic irq
);
    typedef enum {seq_off, seq_on} seq_e;

    logic aw_held;                 // address taken, waiting for data
    logic w_held;                  // data taken, waiting for address
    logic [11:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [7:0] cmp_a_ctl;         // comparator a control
    logic [7:0] event_flags;       // sticky session flags
    logic [2:0] state_field;       // sequencer state code
    seq_e seq;                     // armed session running
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [2:0] irq_set;           // set this cycle
    logic [2:0] irq_clr;           // cleared this cycle
    logic ext_s1, ext_s2, ext_s3;  // external pin synchroniser
    logic ext_level;               // accepted pin level
    logic ext_pulse;
    logic match_a;
    logic [3:0] chan_match;
    logic do_write;
    logic wr_lane0;
    logic arm_req;
    logic disarm_req;
    logic [11:0] ar_idx;
    logic [7:0] rd_byte;
    logic rd_hit;

    assign armed = (seq == seq_on);

    // write channels take address and data in either order, one write in flight
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane0 = do_write && w_strb[0];

    // latch address and data as they arrive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_idx <= s_axi_awaddr[13:2];
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response; unmapped addresses answer slverr, read-only ones okay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            unique case (aw_idx)
                event_flags_idx, seq_status_idx, cmp_a_ctl_idx,
                arm_ctl_idx, irq_status_idx, irq_mask_idx: s_axi_bresp <= resp_okay;
                default: s_axi_bresp <= resp_slverr;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read decode; undefined bits read zero
    assign ar_idx = s_axi_araddr[13:2];
    always_comb begin
        rd_byte = 8'h00;
        rd_hit = 1'b1;
        unique case (ar_idx)
            event_flags_idx: rd_byte = event_flags;                     // R18
            seq_status_idx: rd_byte = {5'h00, state_field};              // R18
            cmp_a_ctl_idx: rd_byte = cmp_a_ctl;                          // R16
            arm_ctl_idx: rd_byte = {7'h00, armed};
            irq_status_idx: rd_byte = {5'h00, irq_status};
            irq_mask_idx: rd_byte = {5'h00, irq_mask};
            default: rd_hit = 1'b0;
        endcase
    end

    // read answer one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= resp_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? resp_okay : resp_slverr;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // comparator a control; frozen during a session so a match cannot change mid-run
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_a_ctl <= cmp_a_ctl_reset;
        end else if (wr_lane0 && aw_idx == cmp_a_ctl_idx && !armed) begin     // R16
            cmp_a_ctl <= w_data[7:0] & cmp_a_ctl_writable;
        end
    end

    // arm control: write 1 arms, write 0 disarms
    assign arm_req = wr_lane0 && aw_idx == arm_ctl_idx && w_data[0] && !armed;
    assign disarm_req = wr_lane0 && aw_idx == arm_ctl_idx && !w_data[0] && armed;

    // external pin: three flops, a change counts when the last two agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            ext_level <= 1'b0;
        end else begin
            ext_s1 <= external_event_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            if (ext_s2 == ext_s3) begin
                ext_level <= ext_s3;
            end
        end
    end
    assign ext_pulse = (ext_s2 == ext_s3) && ext_s3 && !ext_level;

    // comparator a match logic
    always_comb begin
        logic data_eq;
        logic dir_ok;
        data_eq = ((cpu_data ^ cmp_a_data) & cmp_a_data_mask) == 32'h0000_0000;
        // direction qualifier: 0 matches writes, 1 matches reads
        dir_ok = !cmp_a_ctl[direction_qualify_bit]
                 || (cmp_a_ctl[direction_bit] == cpu_read);                   // R13
        match_a = 1'b0;
        if (!cmp_a_ctl[comparator_enable_bit]) begin                          // R15
            match_a = 1'b0;
        end else if (cmp_a_ctl[instruction_select_bit]) begin                 // R12
            // instruction hits are data independent, so qualifiers are ignored
            match_a = cpu_instruction_address_select_valid && (cpu_pc == cmp_a_addr);               // R14
        end else begin
            match_a = cpu_data_valid && (cpu_data_addr == cmp_a_addr) && dir_ok
                      && (cmp_a_ctl[data_mismatch_bit] ? !data_eq : data_eq); // R11
        end
    end
    assign chan_match = {channel_match_in, match_a};

    // registered match towards the sequencer logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comparator_a_match <= 1'b0;
        end else begin
            comparator_a_match <= match_a;
        end
    end

    // session state and state field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq <= seq_off;
            state_field <= state_disarmed;
        end else if (arm_req) begin
            seq <= seq_on;
            state_field <= state_first;                                       // R9
        end else if (armed && disarm_req) begin
            seq <= seq_off;                                                   // R7
        end else if (armed && session_end_event) begin
            seq <= seq_off;
            state_field <= state_disarmed;                                    // R8
        end else if (armed && seq_goto_valid && seq_goto_state <= state_final
                     && seq_goto_state != state_disarmed) begin
            state_field <= seq_goto_state;                                    // R6 R10
        end
    end

    // sticky event flags; arming clears, events only or-in new bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_flags <= 8'h00;
        end else if (arm_req) begin
            event_flags <= 8'h00;                                             // R3
            event_flags[trigger_flag_bit] <= forced_trigger_event;            // R2
        end else if (armed) begin
            if (forced_trigger_event) begin
                event_flags[trigger_flag_bit] <= 1'b1;                        // R2
            end
            if (ext_pulse) begin
                event_flags[external_event_flag_bit] <= 1'b1;                 // R1 R5
            end
            event_flags[channel_match_lsb +: 4] <=
                event_flags[channel_match_lsb +: 4] | chan_match;             // R4 R5
        end
    end

    // interrupt sources and software clears of this cycle
    always_comb begin
        irq_set = 3'h0;
        irq_set[irq_trigger_bit] = forced_trigger_event && (armed || arm_req);
        irq_set[irq_match_bit] = armed && (|chan_match);
        irq_set[irq_end_bit] = armed && session_end_event && !disarm_req;
        irq_clr = (wr_lane0 && aw_idx == irq_status_idx) ? w_data[2:0] : 3'h0;
    end

    // interrupt status: hardware set wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= irq_reset;
            irq_mask <= irq_reset;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            if (wr_lane0 && aw_idx == irq_mask_idx) begin
                irq_mask <= w_data[2:0];
            end
        end
    end

    // level interrupt from any unmasked status bit; a mask bit of 1 blocks
    // registered, so no glitch on the pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & ~irq_mask);
        end
    end

    // checks
    sequence arm_write_s;
        arm_req;
    endsequence

    property arm_forces_first_p;
        @(posedge aclk) disable iff (!aresetn)
        arm_write_s |=> armed && state_field == state_first;
    endproperty
    arm_state_first_a: assert property (arm_forces_first_p)   // R9
        else $error("arming did not force state 001");

    ctl_armed_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        armed && $past(armed) |-> $stable(cmp_a_ctl))   // R16
        else $error("comparator a control changed while armed");

    flags_unarmed_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !armed && !$past(arm_req) && $past(!armed) |-> $stable(event_flags[4:0]))   // R1
        else $error("flags changed while disarmed");

    forced_trigger_event_on_arm_a: assert property (@(posedge aclk) disable iff (!aresetn)
        arm_req && forced_trigger_event |=> event_flags[trigger_flag_bit])   // R2
        else $error("trigger at arming not flagged");

    arm_clears_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
        arm_req |=> event_flags[4:0] == 5'h00)   // R3
        else $error("arming did not clear flags");

    flags_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        armed && !arm_req |=> (event_flags & $past(event_flags)) == $past(event_flags))   // R4
        else $error("a set flag was lost");

    match_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        armed && !arm_req && match_a |=> event_flags[channel_match_lsb])   // R5
        else $error("comparator a match not flagged");

    disarm_keeps_a: assert property (@(posedge aclk) disable iff (!aresetn)
        disarm_req |=> !armed && $stable(state_field))   // R7
        else $error("software disarm altered state field");

    end_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
        armed && session_end_event && !disarm_req && !arm_req
        |=> !armed && state_field == state_disarmed)   // R8
        else $error("internal end did not clear state");

    state_legal_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_field <= state_final)   // R10
        else $error("reserved state code");

    disabled_no_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !cmp_a_ctl[comparator_enable_bit] |=> !comparator_a_match)   // R15
        else $error("disabled comparator matched");

    instruction_address_select_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cmp_a_ctl[comparator_enable_bit] && cmp_a_ctl[instruction_select_bit]
        && cpu_instruction_address_select_valid && cpu_pc == cmp_a_addr |=> comparator_a_match)   // R12 R14
        else $error("instruction address hit missed");

    write_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cmp_a_ctl[2] && !cmp_a_ctl[3] && !cmp_a_ctl[5] && cpu_read
        |=> !comparator_a_match)   // R13
        else $error("read matched in write-only mode");

    read_only_a: assert property (@(posedge aclk) disable iff (!aresetn)   // R13
        cmp_a_ctl[2] && cmp_a_ctl[3] && !cmp_a_ctl[5] && !cpu_read |=> !comparator_a_match)
        else $error("write matched in read-only mode");

    reserved_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)   // R10
        armed && seq_goto_valid && seq_goto_state > state_final && !session_end_event
        |=> $stable(state_field))
        else $error("reserved state code accepted");

    irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == |($past(irq_status) & ~$past(irq_mask)))
        else $error("irq does not follow unmasked status");
endmodule
`default_nettype wire

//--- dbg_event_pkg.sv
// constants for the debug event flag, sequencer status and comparator a control block
// assumes a 32-bit axi4-lite register bus at 100 MHz with one word per register
// Function
// R1 - non-trigger flags set only while armed
// R2 - trigger flag bit 6, armed or arming
// R3 - arming alone clears non-trigger flags
// R4 - set flags never block other flags
// R5 - external bit 4, channel matches bits 3-0
// R6 - state field follows each armed transition
// R7 - software disarm keeps last state
// R8 - internal end returns state to 000
// R9 - arming forces state 001
// R10 - state codes 000 to 100, rest reserved
// R11 - bit 6 selects equal or differ
// R12 - bit 5 selects data or pc address
// R13 - bit 2 qualifies, bit 3 picks direction
// R14 - instruction mode ignores direction bits
// R15 - bit 0 enables comparator a
// R16 - control writes ignored while armed
// R17 - software enables comparator before using matches
// R18 - status registers read-only, undefined bits zero
package dbg_event_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [11:0] event_flags_idx = 12'h10a;
    localparam logic [11:0] seq_status_idx = 12'h10b;
    localparam logic [11:0] cmp_a_ctl_idx = 12'h110;
    localparam logic [11:0] arm_ctl_idx = 12'h100;
    localparam logic [11:0] irq_status_idx = 12'h101;
    localparam logic [11:0] irq_mask_idx = 12'h102;
    // event flag fields
    localparam int trigger_flag_bit = 6;
    localparam int external_event_flag_bit = 4;
    localparam int channel_match_lsb = 0;
    // comparator a control fields
    localparam int data_mismatch_bit = 6;
    localparam int instruction_select_bit = 5;
    localparam int direction_bit = 3;
    localparam int direction_qualify_bit = 2;
    localparam int comparator_enable_bit = 0;
    localparam logic [7:0] cmp_a_ctl_writable = 8'h6d;
    localparam logic [7:0] cmp_a_ctl_reset = 8'h00;
    // interrupt status fields
    localparam int irq_trigger_bit = 0;
    localparam int irq_match_bit = 1;
    localparam int irq_end_bit = 2;
    localparam logic [2:0] irq_reset = 3'h0;
    // sequencer state codes
    localparam logic [2:0] state_disarmed = 3'h0;
    localparam logic [2:0] state_first = 3'h1;
    localparam logic [2:0] state_final = 3'h4;
    // axi responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

//--- cpu_bus_model.sv
// behavioural model of the cpu core buses that the debug block watches
// assumes one clock shared with the block; tasks are entered just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    // clock
    input wire logic aclk,
    // data access bus
    output logic [23:0] cpu_data_addr,
    output logic [31:0] cpu_data,
    output logic cpu_read,
    output logic cpu_data_valid,
    // instruction bus
    output logic [23:0] cpu_pc,
    output logic cpu_instruction_address_select_valid
);
    // idle buses start with junk, never with a value that could match
    initial begin
        cpu_data_addr = 24'h5a5a5a;
        cpu_data = 32'h0f0f0f0f;
        cpu_read = 1'b0;
        cpu_data_valid = 1'b0;
        cpu_pc = 24'ha5a5a5;
        cpu_instruction_address_select_valid = 1'b0;
    end
    // one data access cycle; afterwards the bus shows the inverse, not a held value
    task automatic access(input logic [23:0] a, input logic [31:0] d, input logic rd);
        cpu_data_addr <= a;
        cpu_data <= d;
        cpu_read <= rd;
        cpu_data_valid <= 1'b1;
        @(posedge aclk);
        cpu_data_addr <= ~a;
        cpu_data <= ~d;
        cpu_read <= ~rd;
        cpu_data_valid <= 1'b0;
    endtask
    // one instruction reaching execution
    task automatic fetch(input logic [23:0] pc);
        cpu_pc <= pc;
        cpu_instruction_address_select_valid <= 1'b1;
        @(posedge aclk);
        cpu_pc <= ~pc;
        cpu_instruction_address_select_valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- test_debug_event_status_comparator.sv
// self-checking bench for the debug event flags, sequencer status and comparator a
// assumes the package and the cpu bus model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_debug_event_status_comparator;
    import dbg_event_pkg::*;
    // clock, reset and bus signals
    logic aclk, aresetn;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    // watched buses and events
    logic [23:0] cpu_data_addr, cpu_pc, cmp_a_addr;
    logic [31:0] cpu_data, cmp_a_data, cmp_a_data_mask;
    logic cpu_read, cpu_data_valid, cpu_instruction_address_select_valid;
    logic [2:0] channel_match_in, seq_goto_state;
    logic external_event_pin, forced_trigger_event, session_end_event, seq_goto_valid;
    logic comparator_a_match, armed, irq;
    int miscompares, n_tests;
    // comparator rows: {control, fetch, read, data differs, expected match}
    localparam logic [11:0] rows [12] = '{12'h000, 12'h011, 12'h410, 12'h413, 12'h051,
        12'h054, 12'h0d5, 12'h0d0, 12'h015, 12'h219, 12'h210, 12'h6d9};

    debug_event_status_comparator uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cpu_data_addr(cpu_data_addr),
        .cpu_data(cpu_data), .cpu_read(cpu_read), .cpu_data_valid(cpu_data_valid),
        .cpu_pc(cpu_pc), .cpu_instruction_address_select_valid(cpu_instruction_address_select_valid), .cmp_a_addr(cmp_a_addr),
        .cmp_a_data(cmp_a_data), .cmp_a_data_mask(cmp_a_data_mask),
        .channel_match_in(channel_match_in), .external_event_pin(external_event_pin),
        .forced_trigger_event(forced_trigger_event), .session_end_event(session_end_event),
        .seq_goto_valid(seq_goto_valid), .seq_goto_state(seq_goto_state),
        .comparator_a_match(comparator_a_match), .armed(armed), .irq(irq));
    cpu_bus_model cpu (.aclk(aclk), .cpu_data_addr(cpu_data_addr), .cpu_data(cpu_data),
        .cpu_read(cpu_read), .cpu_data_valid(cpu_data_valid), .cpu_pc(cpu_pc),
        .cpu_instruction_address_select_valid(cpu_instruction_address_select_valid));

    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // byte address of a register index
    function automatic logic [31:0] ba(input logic [11:0] i);
        return {18'h0, i, 2'b00};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // axi write: address and data offered together, each released when taken
    task automatic wrc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        check({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        // one idle edge so the next request never lands in the same time step
        @(posedge aclk);
    endtask
    // axi read and compare of data and response
    task automatic rdc(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, ed);
        check({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // every flag event source but channel 2 at once: channels 3 and 1, trigger, comparator a hit, external edge
    task automatic events();
        channel_match_in <= 3'b101;
        forced_trigger_event <= 1'b1;
        external_event_pin <= 1'b1;
        cpu.access(24'h1234, 32'ha5, 1'b0);
        channel_match_in <= 3'b000;
        forced_trigger_event <= 1'b0;
        // pin held long enough to pass the synchroniser
        repeat (6) @(posedge aclk);
        external_event_pin <= 1'b0;
        @(posedge aclk);
    endtask
    // sequencer moves to state s
    task automatic goto(input logic [2:0] s);
        seq_goto_state <= s;
        seq_goto_valid <= 1'b1;
        @(posedge aclk);
        seq_goto_valid <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog: the sequence needs a few thousand cycles at most
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end
    // main sequence
    initial begin
        miscompares = 0;
        n_tests = 0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        cmp_a_addr = 24'h1234;
        cmp_a_data = 32'ha5;
        cmp_a_data_mask = 32'hffffffff;
        {channel_match_in, seq_goto_state, seq_goto_valid} = '0;
        {external_event_pin, forced_trigger_event, session_end_event} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(ba(event_flags_idx), 32'h0, resp_okay);
        rdc(ba(seq_status_idx), 32'h0, resp_okay);
        rdc(ba(cmp_a_ctl_idx), 32'h0, resp_okay);
        rdc(32'h800, 32'h0, resp_slverr);
        wrc(32'h800, 32'h1, resp_slverr);
        wrc(ba(event_flags_idx), 32'hff, resp_okay);
        wrc(ba(seq_status_idx), 32'hff, resp_okay);
        rdc(ba(event_flags_idx), 32'h0, resp_okay);
        rdc(ba(seq_status_idx), 32'h0, resp_okay);
        wrc(ba(cmp_a_ctl_idx), 32'hff, resp_okay);
        rdc(ba(cmp_a_ctl_idx), 32'h6d, resp_okay);
        // comparator a modes, disarmed so control writes land
        for (int i = 0; i < 12; i++) begin
            wrc(ba(cmp_a_ctl_idx), {24'h0, rows[i][11:4]}, resp_okay);
            if (rows[i][3])
                cpu.fetch(24'h1234);
            else
                cpu.access(24'h1234, rows[i][1] ? 32'h5a : 32'ha5, rows[i][2]);
            #1;
            check({31'h0, comparator_a_match}, {31'h0, rows[i][0]});
            @(posedge aclk);
        end
        // events while disarmed leave the flags alone
        events();
        rdc(ba(event_flags_idx), 32'h0, resp_okay);
        wrc(ba(irq_status_idx), 32'h7, resp_okay);
        rdc(ba(irq_status_idx), 32'h0, resp_okay);
        check({31'h0, irq}, 32'h0);
        // first session, disarmed by software
        wrc(ba(cmp_a_ctl_idx), 32'h1, resp_okay);
        wrc(ba(arm_ctl_idx), 32'h1, resp_okay);
        check({31'h0, armed}, 32'h1);
        rdc(ba(seq_status_idx), 32'h1, resp_okay);
        goto(3'h2);
        rdc(ba(seq_status_idx), 32'h2, resp_okay);
        events();
        rdc(ba(event_flags_idx), 32'h5b, resp_okay);
        wrc(ba(cmp_a_ctl_idx), 32'h0, resp_okay);
        rdc(ba(cmp_a_ctl_idx), 32'h1, resp_okay);
        goto(3'h4);
        rdc(ba(seq_status_idx), 32'h4, resp_okay);
        wrc(ba(arm_ctl_idx), 32'h0, resp_okay);
        check({31'h0, armed}, 32'h0);
        rdc(ba(seq_status_idx), 32'h4, resp_okay);
        rdc(ba(event_flags_idx), 32'h5b, resp_okay);
        rdc(ba(irq_status_idx), 32'h3, resp_okay);
        check({31'h0, irq}, 32'h1);
        wrc(ba(irq_mask_idx), 32'h7, resp_okay);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h0);
        // second session, ended from inside; a trigger lands in the arming cycle
        fork
            wrc(ba(arm_ctl_idx), 32'h1, resp_okay);
            begin
                @(posedge aclk) forced_trigger_event <= 1'b1;
                @(posedge aclk) forced_trigger_event <= 1'b0;
            end
        join
        rdc(ba(event_flags_idx), 32'h40, resp_okay);
        rdc(ba(seq_status_idx), 32'h1, resp_okay);
        goto(3'h3);
        rdc(ba(seq_status_idx), 32'h3, resp_okay);
        goto(3'h5);
        rdc(ba(seq_status_idx), 32'h3, resp_okay);
        session_end_event <= 1'b1;
        @(posedge aclk);
        session_end_event <= 1'b0;
        repeat (2) @(posedge aclk);
        check({31'h0, armed}, 32'h0);
        rdc(ba(seq_status_idx), 32'h0, resp_okay);
        rdc(ba(irq_status_idx), 32'h7, resp_okay);
        wrc(ba(irq_status_idx), 32'h7, resp_okay);
        rdc(ba(irq_status_idx), 32'h0, resp_okay);
        wrc(ba(irq_mask_idx), 32'h0, resp_okay);
        check({31'h0, irq}, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
